// >>> verilog/eam_pkg.sv
// Package with the shared constants and types of the exclusive access monitor.
package eam_pkg;
  localparam int unsigned EAM_CORES = 2;
  localparam int unsigned EAM_ADDR_W = 32;
  localparam int unsigned EAM_DATA_W = 64;
  localparam int unsigned EAM_MEM_WORDS = 16;
  localparam logic EAM_STATUS_OK = 1'b0;
  localparam logic EAM_STATUS_FAIL = 1'b1;
  localparam int unsigned EAM_RESP_LAT = 2;

  typedef enum logic [2:0] {
    EAM_OP_LOAD,
    EAM_OP_STORE,
    EAM_OP_LOAD_EXCL,
    EAM_OP_STORE_EXCL,
    EAM_OP_CLEAR_EXCL
  } eam_op_t;

  typedef enum logic [1:0] {
    EAM_SZ_BYTE,
    EAM_SZ_HALF,
    EAM_SZ_WORD,
    EAM_SZ_DOUBLE
  } eam_size_t;

  // Byte lanes touched by an access of the given size within a doubleword.
  function automatic logic [7:0] eam_lanes(input eam_size_t sz, input logic [2:0] off);
    logic [7:0] base;
    base = 8'h01;
    case (sz)
      EAM_SZ_BYTE: base = 8'h01;
      EAM_SZ_HALF: base = 8'h03;
      EAM_SZ_WORD: base = 8'h0f;
      default: base = 8'hff;
    endcase
    return 8'(base << off);
  endfunction
endpackage

// >>> verilog/eam_mem_if.sv
// Interface between the monitor core logic and its memory module.
`timescale 1ns/1ps
`default_nettype none
interface eam_mem_if #(parameter int AW = 4, parameter int DW = 64);
  logic req;
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] lanes;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output req, output we, output addr, output lanes, output wdata, input rdata);
  modport mem (input req, input we, input addr, input lanes, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> verilog/eam_mem.sv
// Small memory slave behind the monitor, with registered read data.
`timescale 1ns/1ps
`default_nettype none
module eam_mem #(
  parameter int WORDS = 16
) (
  // Clock
  input wire logic clock_i,
  // Access port
  eam_mem_if.mem bus
);
  logic [63:0] store_r [WORDS];
  logic [63:0] rdata_r;

  always_ff @(posedge clock_i) begin
    if (bus.req && bus.we) begin
      for (int b = 0; b < 8; b++) begin
        if (bus.lanes[b]) begin
          store_r[bus.addr][b*8 +: 8] <= bus.wdata[b*8 +: 8];
        end
      end
    end
    if (bus.req) begin
      rdata_r <= store_r[bus.addr];
    end
  end

  assign bus.rdata = rdata_r;
endmodule // eam_mem
`default_nettype wire

// >>> verilog/eam_global.sv
// Global reservation table that sits in front of the shared memory.
`timescale 1ns/1ps
`default_nettype none
module eam_global #(
  parameter int CORES = 2,
  parameter int AW = 32
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Access seen at the memory
  input wire logic acc_i,
  input wire logic [$clog2(CORES)-1:0] acc_core_i,
  input wire eam_pkg::eam_op_t acc_op_i,
  input wire logic [AW-1:0] acc_addr_i,
  // Result for a store_exclusive in the same cycle
  output logic pass_o
);
  import eam_pkg::*;

  logic [CORES-1:0] valid_r, valid_nxt;
  logic [AW-1:0] addr_r [CORES];
  logic [AW-1:0] addr_nxt [CORES];
  logic hit;

  // Reservations here are independent of the per-core state.
  assign hit = valid_r[acc_core_i] && (addr_r[acc_core_i][AW-1:3] == acc_addr_i[AW-1:3]);
  assign pass_o = hit;

  always_comb begin
    valid_nxt = valid_r;
    addr_nxt = addr_r;
    if (acc_i) begin
      case (acc_op_i)
        EAM_OP_LOAD_EXCL: begin
          valid_nxt[acc_core_i] = 1'b1; // see RL11
          addr_nxt[acc_core_i] = acc_addr_i;
        end
        EAM_OP_STORE, EAM_OP_STORE_EXCL: begin
          for (int c = 0; c < CORES; c++) begin
            // An ordinary store, or a store_exclusive that hits here, cancels every reservation on its doubleword.
            if (addr_r[c][AW-1:3] == acc_addr_i[AW-1:3] &&
                (acc_op_i == EAM_OP_STORE || hit)) begin
              valid_nxt[c] = 1'b0; // see RL4
            end
          end
          if (acc_op_i == EAM_OP_STORE_EXCL) begin
            valid_nxt[acc_core_i] = 1'b0;
          end
        end
        EAM_OP_CLEAR_EXCL: valid_nxt[acc_core_i] = 1'b0; // see RL3
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      valid_r <= '0;
      for (int c = 0; c < CORES; c++) addr_r[c] <= '0;
    end else begin
      valid_r <= valid_nxt;
      addr_r <= addr_nxt;
    end
  end
endmodule // eam_global
`default_nettype wire

// >>> verilog/eam_top.sv
// Exclusive access monitor: per-core local monitors, a global monitor and memory.
// Notes on behaviour
// RL1: A load_exclusive returns the data and reserves the address for the issuing core.
// RL2: A store_exclusive writes only with a valid reservation, status 0 on success, 1 otherwise.
// RL3: A clear_exclusive drops the issuing core's reservation without touching memory.
// RL4: In shareable memory a write by another core to the reserved address cancels it.
// RL5: In non-shareable memory an ordinary write by the owner to its address cancels it.
// RL6: Each core holds one reservation; a new load_exclusive replaces the old one.
// RL7: Every store_exclusive leaves its core with no reservation.
// RL8: The local monitor fails a store_exclusive that no load_exclusive preceded.
// RL9: The local monitor may optionally ignore the address of a store_exclusive.
// RL10: Exclusive accesses work for byte, halfword, word and doubleword sizes.
// RL11: A global monitor before the memory tracks reservations independently of cores.
// RL12: An exclusive sequence to memory that no monitor covers always fails with status 1.
// RL13: Software clears the reservation on every context switch.
// RL14: Exclusive accesses go only to Normal memory, never to device regions.
// RL15: The status returns with the completion and the update is seen by the next access.
`timescale 1ns/1ps
`default_nettype none
module eam_top #(
  parameter int CORES = eam_pkg::EAM_CORES,
  parameter int AW = eam_pkg::EAM_ADDR_W,
  parameter int WORDS = eam_pkg::EAM_MEM_WORDS,
  parameter bit LOCAL_CHECKS_ADDR = 1'b1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Request from the arbitrated core load/store path
  input wire logic req_valid_i,
  input wire logic [$clog2(CORES)-1:0] req_core_i,
  input wire eam_pkg::eam_op_t req_op_i,
  input wire eam_pkg::eam_size_t req_size_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic [63:0] req_wdata_i,
  input wire logic req_shareable_i,
  input wire logic req_covered_i,
  // Completion
  output logic rsp_valid_o,
  output logic [$clog2(CORES)-1:0] rsp_core_o,
  output logic [63:0] rsp_rdata_o,
  output logic rsp_status_o,
  output logic [CORES-1:0] resv_valid_o
);
  import eam_pkg::*;

  localparam int MAW = $clog2(WORDS);
  localparam int CW = $clog2(CORES);

  eam_mem_if #(.AW(MAW), .DW(64)) mbus ();

  logic [CORES-1:0] lv_r, lv_nxt;
  logic [AW-1:0] la_r [CORES];
  logic [AW-1:0] la_nxt [CORES];
  logic p_valid_r, p_valid_nxt;
  logic [CW-1:0] p_core_r, p_core_nxt;
  logic p_status_r, p_status_nxt;
  logic p_read_r, p_read_nxt;
  logic [2:0] p_off_r, p_off_nxt;
  eam_size_t p_size_r, p_size_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [CW-1:0] rsp_core_r, rsp_core_nxt;
  logic [63:0] rsp_rdata_r, rsp_rdata_nxt;
  logic rsp_status_r, rsp_status_nxt;
  logic gpass, lpass, sx_ok, is_sx, is_st, wr_en;

  assign is_sx = req_valid_i && req_op_i == EAM_OP_STORE_EXCL;
  assign is_st = req_valid_i && req_op_i == EAM_OP_STORE;

  // Address match can be dropped to save comparators in the local monitor.
  assign lpass = lv_r[req_core_i] &&
    (!LOCAL_CHECKS_ADDR || la_r[req_core_i][AW-1:3] == req_addr_i[AW-1:3]); // see RL9 // see RL8
  // Shareable targets also need the global monitor; uncovered targets always fail.
  assign sx_ok = req_covered_i && lpass && (!req_shareable_i || gpass); // see RL12 // see RL2
  assign wr_en = is_st || (is_sx && sx_ok);

  eam_global #(.CORES(CORES), .AW(AW)) u_global (
    .clock_i(clock_i),
    .reset_i(reset_i),
    // A shareable, covered clear_exclusive goes to the global table too, or a stale entry would outlive it.
    .acc_i(req_valid_i && req_shareable_i && req_covered_i), // see RL3
    .acc_core_i(req_core_i),
    .acc_op_i(req_op_i),
    .acc_addr_i(req_addr_i),
    .pass_o(gpass)
  );

  assign mbus.req = req_valid_i && req_op_i != EAM_OP_CLEAR_EXCL; // see RL3
  assign mbus.we = wr_en;
  assign mbus.addr = req_addr_i[MAW+2:3];
  assign mbus.lanes = eam_lanes(req_size_i, req_addr_i[2:0]); // see RL10
  assign mbus.wdata = req_wdata_i << {req_addr_i[2:0], 3'h0};

  eam_mem #(.WORDS(WORDS)) u_mem (
    .clock_i(clock_i),
    .bus(mbus)
  );

  // Local monitor state.
  always_comb begin
    lv_nxt = lv_r;
    la_nxt = la_r;
    if (req_valid_i) begin
      case (req_op_i)
        EAM_OP_LOAD_EXCL: begin
          lv_nxt[req_core_i] = 1'b1; // see RL1 // see RL6
          la_nxt[req_core_i] = req_addr_i;
        end
        EAM_OP_STORE_EXCL: lv_nxt[req_core_i] = 1'b0; // see RL7
        EAM_OP_CLEAR_EXCL: lv_nxt[req_core_i] = 1'b0; // see RL3 // see RL13
        EAM_OP_STORE: begin
          if (!req_shareable_i && la_r[req_core_i][AW-1:3] == req_addr_i[AW-1:3]) begin
            lv_nxt[req_core_i] = 1'b0; // see RL5
          end
        end
        default: ;
      endcase
      // A shareable write that really lands cancels other cores' reservations on its doubleword.
      if (wr_en && req_shareable_i) begin
        for (int c = 0; c < CORES; c++) begin
          if (c != int'(req_core_i) && la_r[c][AW-1:3] == req_addr_i[AW-1:3]) begin
            lv_nxt[c] = 1'b0; // see RL4
          end
        end
      end
    end
  end

  // Keeps only the bytes that an access of the given size returns, right-aligned.
  function automatic logic [63:0] data_mask(input eam_size_t sz);
    logic [63:0] m;
    m = 64'hffffffffffffffff;
    case (sz)
      EAM_SZ_BYTE: m = 64'h00000000000000ff;
      EAM_SZ_HALF: m = 64'h000000000000ffff;
      EAM_SZ_WORD: m = 64'h00000000ffffffff;
      default: m = 64'hffffffffffffffff;
    endcase
    return m;
  endfunction

  // Two-stage response: memory read data arrive one cycle after the request.
  always_comb begin
    p_valid_nxt = req_valid_i;
    p_core_nxt = req_core_i;
    p_status_nxt = is_sx ? (sx_ok ? EAM_STATUS_OK : EAM_STATUS_FAIL) : EAM_STATUS_OK; // see RL2
    p_read_nxt = req_op_i == EAM_OP_LOAD || req_op_i == EAM_OP_LOAD_EXCL;
    p_off_nxt = req_addr_i[2:0];
    p_size_nxt = req_size_i;
    rsp_valid_nxt = p_valid_r;
    rsp_core_nxt = p_core_r;
    rsp_status_nxt = p_status_r; // see RL15
    rsp_rdata_nxt = 64'h0; // see RL1
    if (p_read_r) begin
      rsp_rdata_nxt = (mbus.rdata >> {p_off_r, 3'h0}) & data_mask(p_size_r); // see RL10
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      lv_r <= '0;
      for (int c = 0; c < CORES; c++) la_r[c] <= '0;
      p_valid_r <= 1'b0;
      p_core_r <= '0;
      p_status_r <= 1'b0;
      p_read_r <= 1'b0;
      p_off_r <= 3'h0;
      p_size_r <= EAM_SZ_BYTE;
      rsp_valid_r <= 1'b0;
      rsp_core_r <= '0;
      rsp_rdata_r <= 64'h0;
      rsp_status_r <= 1'b0;
    end else begin
      lv_r <= lv_nxt;
      la_r <= la_nxt;
      p_valid_r <= p_valid_nxt;
      p_core_r <= p_core_nxt;
      p_status_r <= p_status_nxt;
      p_read_r <= p_read_nxt;
      p_off_r <= p_off_nxt;
      p_size_r <= p_size_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_core_r <= rsp_core_nxt;
      rsp_rdata_r <= rsp_rdata_nxt;
      rsp_status_r <= rsp_status_nxt;
    end
  end

  assign rsp_valid_o = rsp_valid_r;
  assign rsp_core_o = rsp_core_r;
  assign rsp_rdata_o = rsp_rdata_r;
  assign rsp_status_o = rsp_status_r;
  assign resv_valid_o = lv_r;

  sequence s_lx;
    req_valid_i && req_op_i == EAM_OP_LOAD_EXCL;
  endsequence
  sequence s_sx;
    req_valid_i && req_op_i == EAM_OP_STORE_EXCL;
  endsequence

  property p_lx_sets;
    @(posedge clock_i) disable iff (reset_i) s_lx |=> lv_r[$past(req_core_i)];
  endproperty
  a_lx_sets: assert property (p_lx_sets) else $error("load_exclusive did not reserve"); // see RL1

  property p_sx_clears;
    @(posedge clock_i) disable iff (reset_i) s_sx |=> !lv_r[$past(req_core_i)];
  endproperty
  a_sx_clears: assert property (p_sx_clears) else $error("reservation left after store_exclusive"); // see RL7

  property p_no_resv_fails;
    @(posedge clock_i) disable iff (reset_i)
      (s_sx and !lv_r[req_core_i]) |-> ##2 (rsp_valid_o && rsp_status_o == EAM_STATUS_FAIL);
  endproperty
  a_no_resv_fails: assert property (p_no_resv_fails) else $error("store_exclusive passed unreserved"); // see RL8

  property p_uncovered;
    @(posedge clock_i) disable iff (reset_i)
      (s_sx and !req_covered_i) |-> !mbus.we ##2 rsp_status_o;
  endproperty
  a_uncovered: assert property (p_uncovered) else $error("uncovered store_exclusive passed"); // see RL12

  property p_clear;
    @(posedge clock_i) disable iff (reset_i)
      (req_valid_i && req_op_i == EAM_OP_CLEAR_EXCL) |-> !mbus.req ##1 !lv_r[$past(req_core_i)];
  endproperty
  a_clear: assert property (p_clear) else $error("clear_exclusive misbehaved"); // see RL3

  property p_sx_write;
    @(posedge clock_i) disable iff (reset_i)
      s_sx |-> (mbus.we == sx_ok) ##2 (rsp_status_o == !$past(sx_ok, 2));
  endproperty
  a_sx_write: assert property (p_sx_write) else $error("store_exclusive status and write differ"); // see RL2

  property p_own_store;
    @(posedge clock_i) disable iff (reset_i)
      (is_st && !req_shareable_i && la_r[req_core_i][AW-1:3] == req_addr_i[AW-1:3])
      |=> !lv_r[$past(req_core_i)];
  endproperty
  a_own_store: assert property (p_own_store) else $error("own store kept reservation"); // see RL5

  property p_latency;
    @(posedge clock_i) disable iff (reset_i) req_valid_i |-> ##2 rsp_valid_o;
  endproperty
  a_latency: assert property (p_latency) else $error("completion not two cycles later"); // see RL15

  // Other cores whose reservation lies in the requested doubleword.
  logic [CORES-1:0] oth_match;
  always_comb begin
    oth_match = '0;
    for (int c = 0; c < CORES; c++) begin
      oth_match[c] = c != int'(req_core_i) && la_r[c][AW-1:3] == req_addr_i[AW-1:3];
    end
  end

  sequence s_clx;
    req_valid_i && req_op_i == EAM_OP_CLEAR_EXCL;
  endsequence
  sequence s_shared_wr;
    req_valid_i && wr_en && req_shareable_i;
  endsequence

  property p_repl;
    @(posedge clock_i) disable iff (reset_i)
      s_lx |=> la_r[$past(req_core_i)] == $past(req_addr_i);
  endproperty
  a_repl: assert property (p_repl) else $error("load_exclusive kept the old address"); // see RL6

  property p_fwr;
    @(posedge clock_i) disable iff (reset_i)
      s_shared_wr |=> (lv_r & $past(oth_match)) == '0;
  endproperty
  a_fwr: assert property (p_fwr) else $error("foreign write kept reservation"); // see RL4

  property p_lwidth;
    @(posedge clock_i) disable iff (reset_i)
      s_lx |-> ##2 ((rsp_rdata_o & ~data_mask($past(req_size_i, 2))) == 64'h0);
  endproperty
  a_lwidth: assert property (p_lwidth) else $error("load data wider than access"); // see RL10

  property p_gpass;
    @(posedge clock_i) disable iff (reset_i)
      (s_sx and req_shareable_i && !gpass) |-> !mbus.we ##2 (rsp_status_o == EAM_STATUS_FAIL);
  endproperty
  a_gpass: assert property (p_gpass) else $error("global refusal ignored"); // see RL11

  property p_clr_rsp;
    @(posedge clock_i) disable iff (reset_i)
      s_clx |-> ##2 (rsp_valid_o && rsp_status_o == EAM_STATUS_OK && rsp_rdata_o == 64'h0);
  endproperty
  a_clr_rsp: assert property (p_clr_rsp) else $error("clear_exclusive completion wrong"); // see RL3

  property p_lx_ok;
    @(posedge clock_i) disable iff (reset_i)
      s_lx |-> ##2 (rsp_valid_o && rsp_status_o == EAM_STATUS_OK);
  endproperty
  a_lx_ok: assert property (p_lx_ok) else $error("load_exclusive completion wrong"); // see RL1

  property p_rsp_core;
    @(posedge clock_i) disable iff (reset_i)
      req_valid_i |-> ##2 (rsp_core_o == $past(req_core_i, 2));
  endproperty
  a_rsp_core: assert property (p_rsp_core) else $error("completion for wrong core"); // see RL15

  property p_st_ok;
    @(posedge clock_i) disable iff (reset_i)
      (req_valid_i && req_op_i == EAM_OP_STORE) |-> ##2 (rsp_status_o == EAM_STATUS_OK);
  endproperty
  a_st_ok: assert property (p_st_ok) else $error("ordinary store reported failure"); // see RL15
endmodule // eam_top
`default_nettype wire

// >>> test/eam_core_model.sv
// Behavioural model of the core load/store path that issues requests to the monitor.
`timescale 1ns/1ps
`default_nettype none
module eam_core_model (
  // Clock
  input wire logic clock_i,
  // Request towards the monitor
  output logic req_valid_o,
  output logic req_core_o,
  output var eam_pkg::eam_op_t req_op_o,
  output var eam_pkg::eam_size_t req_size_o,
  output logic [eam_pkg::EAM_ADDR_W-1:0] req_addr_o,
  output logic [63:0] req_wdata_o,
  output logic req_shareable_o,
  output logic req_covered_o
);
  import eam_pkg::*;

  initial begin
    req_valid_o = 1'h0;
    req_core_o = 1'h0;
    req_op_o = EAM_OP_LOAD;
    req_size_o = EAM_SZ_DOUBLE;
    req_addr_o = 32'h0;
    req_wdata_o = 64'h0;
    req_shareable_o = 1'h0;
    req_covered_o = 1'h1;
  end

  // Called at a falling edge; returns one falling edge later with the request still up,
  // so that a caller may chain requests back to back.
  // Only Normal memory is ever targeted; this path has no device attribute.
  task automatic send(input logic c, input eam_op_t op, input eam_size_t sz,
                      input logic [31:0] a, input logic [63:0] wd, input logic sh,
                      input logic cov);
    req_valid_o = 1'h1;
    req_core_o = c;
    req_op_o = op;
    req_size_o = sz;
    req_addr_o = a;
    req_wdata_o = wd;
    req_shareable_o = sh;
    req_covered_o = cov;
    @(negedge clock_i);
  endtask

  // Released address and write-data lines show inverted values so that a stale value is never mistaken for live.
  task automatic idle();
    req_valid_o = 1'h0;
    req_addr_o = ~req_addr_o;
    req_wdata_o = ~req_wdata_o;
  endtask

  // A context switch always drops the outgoing thread's reservation.
  task automatic ctx_switch(input logic c);
    send(c, EAM_OP_CLEAR_EXCL, EAM_SZ_DOUBLE, ~req_addr_o, ~req_wdata_o, 1'h1, 1'h1);
  endtask
endmodule // eam_core_model
`default_nettype wire

// >>> test/eam_top_tb_top.sv
// Self-checking testbench of the exclusive access monitor.
`timescale 1ns/1ps
`default_nettype none
module eam_top_tb_top;
  import eam_pkg::*;
  typedef struct packed {
    logic c;
    eam_op_t op;
    eam_size_t sz;
    logic [7:0] a;
    logic [63:0] wd;
    logic sh;
    logic cov;
    logic st;
    logic [63:0] rd;
    logic [2:0] rv;
  } eam_row_t;
  localparam eam_op_t LD = EAM_OP_LOAD;
  localparam eam_op_t ST = EAM_OP_STORE;
  localparam eam_op_t LE = EAM_OP_LOAD_EXCL;
  localparam eam_op_t SE = EAM_OP_STORE_EXCL;
  localparam eam_op_t CL = EAM_OP_CLEAR_EXCL;
  localparam eam_size_t B = EAM_SZ_BYTE;
  localparam eam_size_t H = EAM_SZ_HALF;
  localparam eam_size_t W = EAM_SZ_WORD;
  localparam eam_size_t D = EAM_SZ_DOUBLE;
  localparam logic Y = 1'h1;
  localparam logic N = 1'h0;
  // Bit 2 of the expected reservation field means the reservation is not compared.
  localparam eam_row_t ROWS [0:28] = '{
    '{N,ST,D,8'h08,64'h0123456789abcdef,Y,Y,N,64'h0,3'h0},
    '{N,LE,B,8'h0b,64'h0,Y,Y,N,64'h89,3'h1},
    '{N,SE,B,8'h0b,64'h5a,Y,Y,N,64'h0,3'h0},
    '{N,LE,H,8'h0c,64'h0,Y,Y,N,64'h4567,3'h1},
    '{N,SE,H,8'h0c,64'hbeef,Y,Y,N,64'h0,3'h0},
    '{Y,LE,W,8'h08,64'h0,Y,Y,N,64'h5aabcdef,3'h2},
    '{Y,SE,W,8'h08,64'h76543210,Y,Y,N,64'h0,3'h0},
    '{Y,LD,D,8'h08,64'h0,Y,Y,N,64'h0123beef76543210,3'h0},
    '{N,SE,D,8'h08,64'h0,Y,Y,Y,64'h0,3'h0},
    '{Y,LE,D,8'h08,64'h0,Y,Y,N,64'h0123beef76543210,3'h2},
    '{N,ST,D,8'h08,64'h33,Y,Y,N,64'h0,3'h0},
    '{Y,SE,D,8'h08,64'h44,Y,Y,Y,64'h0,3'h0},
    '{N,ST,D,8'h10,64'h77,N,Y,N,64'h0,3'h0},
    '{N,LE,D,8'h10,64'h0,N,Y,N,64'h77,3'h1},
    '{N,ST,D,8'h10,64'h66,N,Y,N,64'h0,3'h0},
    '{N,SE,D,8'h10,64'h55,N,Y,Y,64'h0,3'h0},
    '{N,LE,D,8'h08,64'h0,Y,Y,N,64'h33,3'h1},
    '{N,LE,D,8'h10,64'h0,Y,Y,N,64'h66,3'h1},
    '{N,SE,D,8'h08,64'h99,Y,Y,Y,64'h0,3'h0},
    '{Y,LE,D,8'h10,64'h0,N,Y,N,64'h66,3'h2},
    '{Y,CL,D,8'h10,64'h0,N,Y,N,64'h0,3'h0},
    '{Y,SE,D,8'h10,64'h11,N,Y,Y,64'h0,3'h0},
    '{Y,LE,D,8'h08,64'h0,Y,N,N,64'h33,3'h4},
    '{Y,SE,D,8'h08,64'hee,Y,N,Y,64'h0,3'h4},
    '{Y,LD,D,8'h08,64'h0,Y,Y,N,64'h33,3'h0},
    '{Y,LE,D,8'h08,64'h0,Y,Y,N,64'h33,3'h2},
    '{Y,CL,D,8'h08,64'h0,Y,Y,N,64'h0,3'h0},
    '{Y,LE,D,8'h08,64'h0,Y,N,N,64'h33,3'h2},
    '{Y,SE,D,8'h08,64'h88,Y,Y,Y,64'h0,3'h0}
  };
  logic clock_i;
  logic reset_i;
  logic req_valid_i;
  logic req_core_i;
  eam_op_t req_op_i;
  eam_size_t req_size_i;
  logic [EAM_ADDR_W-1:0] req_addr_i;
  logic [63:0] req_wdata_i;
  logic req_shareable_i;
  logic req_covered_i;
  logic rsp_valid_o;
  logic rsp_core_o;
  logic [63:0] rsp_rdata_o;
  logic rsp_status_o;
  logic [1:0] resv_valid_o;
  logic [65:0] rsp_q [$];
  logic [65:0] got;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  eam_top eam_top_inst (
    .clock_i(clock_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_core_i(req_core_i), .req_op_i(req_op_i), .req_size_i(req_size_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_shareable_i(req_shareable_i), .req_covered_i(req_covered_i),
    .rsp_valid_o(rsp_valid_o), .rsp_core_o(rsp_core_o), .rsp_rdata_o(rsp_rdata_o),
    .rsp_status_o(rsp_status_o), .resv_valid_o(resv_valid_o)
  );

  eam_core_model eam_core_model_inst (
    .clock_i(clock_i), .req_valid_o(req_valid_i), .req_core_o(req_core_i),
    .req_op_o(req_op_i), .req_size_o(req_size_i), .req_addr_o(req_addr_i),
    .req_wdata_o(req_wdata_i), .req_shareable_o(req_shareable_i),
    .req_covered_o(req_covered_i)
  );

  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  // Completions are queued as they come, so chained requests lose none of them.
  always @(negedge clock_i) begin
    if (rsp_valid_o === 1'h1) begin
      rsp_q.push_back({rsp_core_o, rsp_status_o, rsp_rdata_o});
    end
  end

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk(input bit ok, input string what);
    cmp_count++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic get_rsp(output logic [65:0] g);
    for (int i = 0; i < 8 && rsp_q.size() == 0; i++) @(posedge clock_i);
    g = 66'h0;
    if (rsp_q.size() == 0) begin
      chk(1'b0, "no completion arrived");
    end else begin
      g = rsp_q.pop_front();
    end
  endtask

  task automatic do_op(input eam_row_t r);
    @(negedge clock_i);
    eam_core_model_inst.send(r.c, r.op, r.sz, {24'h0, r.a}, r.wd, r.sh, r.cov);
    eam_core_model_inst.idle();
    if (!r.rv[2]) chk(resv_valid_o === r.rv[1:0], "reservation bits");
    get_rsp(got);
    chk(got === {r.c, r.st, r.rd}, "completion core, status or data");
  endtask

  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    reset_i = 1'h1;
    repeat (10) @(posedge clock_i);
    @(negedge clock_i);
    chk(resv_valid_o === 2'h0 && rsp_valid_o === 1'h0, "state under reset");
    reset_i = 1'h0;
    foreach (ROWS[i]) do_op(ROWS[i]);
    // Foreign write lands between the load and the store of core 0.
    @(negedge clock_i);
    eam_core_model_inst.send(N, LE, D, 32'h8, 64'h0, Y, Y);
    eam_core_model_inst.send(Y, ST, D, 32'h8, 64'h21, Y, Y);
    eam_core_model_inst.send(N, SE, D, 32'h8, 64'h22, Y, Y);
    eam_core_model_inst.idle();
    repeat (3) get_rsp(got);
    chk(got === {N, EAM_STATUS_FAIL, 64'h0}, "chained store succeeded");
    do_op('{Y,LE,D,8'h08,64'h0,Y,Y,N,64'h21,3'h2});
    @(negedge clock_i);
    eam_core_model_inst.ctx_switch(Y);
    eam_core_model_inst.idle();
    chk(resv_valid_o === 2'h0, "context switch kept reservation");
    get_rsp(got);
    do_op('{Y,SE,D,8'h08,64'h23,Y,Y,Y,64'h0,3'h0});
    // A reservation must not survive a reset in mid-run.
    do_op('{N,LE,D,8'h08,64'h0,Y,Y,N,64'h21,3'h1});
    @(negedge clock_i);
    reset_i = 1'h1;
    repeat (3) @(negedge clock_i);
    chk(resv_valid_o === 2'h0 && rsp_valid_o === 1'h0, "state under second reset");
    reset_i = 1'h0;
    do_op('{N,SE,D,8'h08,64'h24,Y,Y,Y,64'h0,3'h0});
    wrap_up();
  end
endmodule // eam_top_tb_top
`default_nettype wire
